/* hdl/pwr_seq_defs.svh */
// Constants for the power mode and boot select sequencer
`ifndef PWR_SEQ_DEFS_SVH
`define PWR_SEQ_DEFS_SVH

`define ACT_STEPS_W      4
`define ACT_STEP_OSC     4'h2
`define ACT_STEP_DONE    4'h5
`define WAKE_CNT_W       16
`define SERIAL_ADDR_LO   32'h100007f4
`define SERIAL_ADDR_HI   32'h100007f8
`define SERIAL_PAD       16'haa55
`define BKPT_NUM         3'h4
`define WATCH_NUM        3'h2
`define BKPT_CNT_W       3

`endif

/* hdl/pwr_seq_pkg.sv */
// Types for the power mode and boot select sequencer
package pwr_seq_pkg;

    typedef enum logic [2:0] {
        MODE_RESET,
        MODE_WAKE_SEQ,
        MODE_ACTIVE,
        MODE_SLEEP,
        MODE_RADIO_RX,
        MODE_RADIO_TX
    } pmode_t;

    typedef struct packed {
        logic regulators_on;
        logic lf_osc_on;
        logic hf_osc_on;
        logic radio_if_on;
        logic core_run;
        logic debug_on;
        logic rx_on;
        logic tx_on;
    } power_ctl_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
    } serial_req_t;

    typedef struct packed {
        logic        valid;
        logic        hit;
        logic [31:0] data;
    } serial_rsp_t;

endpackage

/* hdl/serial_rom.sv */
// Unique serial number read port with fixed padding
`timescale 1ns/1ps
`default_nettype none
`include "pwr_seq_defs.svh"

module serial_rom
    import pwr_seq_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic [47:0] serial_id,
    input  wire serial_req_t req,
    output serial_rsp_t      rsp
);

    // Two words: low word holds bytes 0..3, high word bytes 4..5 plus pad
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rsp <= '0;
        end else begin
            rsp.valid <= req.valid;
            rsp.hit   <= 1'b0;
            rsp.data  <= 32'h0000_0000;
            if (req.valid && req.addr == `SERIAL_ADDR_LO) begin
                rsp.hit  <= 1'b1;
                rsp.data <= serial_id[31:0];
            end else if (req.valid && req.addr == `SERIAL_ADDR_HI) begin
                rsp.hit  <= 1'b1;
                rsp.data <= {`SERIAL_PAD, serial_id[47:32]};
            end
        end
    end

endmodule

`default_nettype wire

/* hdl/power_mode_boot_select.sv */
// Power mode sequencer with boot source selection and serial number port
`timescale 1ns/1ps
`default_nettype none
`include "pwr_seq_defs.svh"

// How it works
// - While external reset is high the block sits in reset mode with regulators, clocks and radio off.
// - On reset release the activation sequence runs at once and ends in active mode.
// - Sleep keeps one low-speed oscillator running and turns off high-speed oscillators and radio.
// - Sleep entry and exit leave logic state and memory untouched.
// - Sleep ends in active mode when the internal wake timer expires.
// - Active mode powers all interfaces, the radio, supplies, the fast oscillator and runs the core.
// - Radio mode is active mode plus the transceiver, in exactly one of receive or transmit.
// - A high boot strap at reset selects the ROM bootloader, otherwise the flash application.
// - The debug port is unpowered while sleeping, so debug access is lost there.
// - The six-byte serial number reads as two words at fixed addresses padded with a fixed pattern.
// - Debug support offers four breakpoint and two watchpoint comparators.
module power_mode_boot_select
    import pwr_seq_pkg::*;
(
    input  wire logic                   core_clk,
    input  wire logic                   rst,
    input  wire logic                   boot_strap_pin,
    input  wire logic                   lf_xtal_sel,
    input  wire logic                   sleep_req,
    input  wire logic [`WAKE_CNT_W-1:0] sleep_ticks,
    input  wire logic                   radio_rx_req,
    input  wire logic                   radio_tx_req,
    input  wire logic                   radio_done,
    input  wire logic [47:0]            serial_id,
    input  wire serial_req_t            serial_req,
    input  wire logic [31:0]            pc_addr,
    input  wire logic [31:0]            data_addr,
    input  wire logic                   data_valid,
    input  wire logic [3:0][31:0]       bkpt_addr,
    input  wire logic [3:0]             bkpt_en,
    input  wire logic [1:0][31:0]       watch_addr,
    input  wire logic [1:0]             watch_en,
    output power_ctl_t                  power_ctl,
    output logic                        lf_xtal_on,
    output logic                        lf_ring_on,
    output logic                        boot_from_rom,
    output logic                        boot_valid,
    output pmode_t                      mode,
    output serial_rsp_t                 serial_rsp,
    output logic                        debug_halt,
    output logic [3:0]                  bkpt_hit,
    output logic [1:0]                  watch_hit
);

    pmode_t                  mode_nxt;
    logic [`ACT_STEPS_W-1:0] act_step_r;
    logic [`WAKE_CNT_W-1:0]  wake_cnt_r;
    logic                    boot_taken_r;
    logic                    lf_xtal_sel_r;
    logic [3:0]              bkpt_raw;
    logic [1:0]              watch_raw;

    // Comparator used by both breakpoint and watchpoint units
    function automatic logic addr_match(input logic        en,
                                        input logic [31:0] a,
                                        input logic [31:0] b);
        addr_match = en && (a == b);
    endfunction

    // Mode transitions
    always_comb begin
        mode_nxt = mode;
        unique case (mode)
            MODE_RESET: begin
                mode_nxt = MODE_WAKE_SEQ;
            end
            MODE_WAKE_SEQ: begin
                if (act_step_r == `ACT_STEP_DONE) begin
                    mode_nxt = MODE_ACTIVE;
                end
            end
            MODE_ACTIVE: begin
                if (sleep_req) begin
                    mode_nxt = MODE_SLEEP;
                end else if (radio_rx_req) begin
                    mode_nxt = MODE_RADIO_RX;
                end else if (radio_tx_req) begin
                    mode_nxt = MODE_RADIO_TX;
                end
            end
            MODE_SLEEP: begin
                if (wake_cnt_r == '0) begin
                    mode_nxt = MODE_ACTIVE;
                end
            end
            MODE_RADIO_RX, MODE_RADIO_TX: begin
                if (radio_done) begin
                    mode_nxt = MODE_ACTIVE;
                end
            end
            default: begin
                mode_nxt = MODE_RESET;
            end
        endcase
    end

    // Reset holds the machine in reset mode; otherwise only an illegal mode value sends it back there
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mode <= MODE_RESET;
        end else begin
            mode <= mode_nxt;
        end
    end

    // Activation sequence step counter
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            act_step_r <= '0;
        end else if (mode == MODE_WAKE_SEQ) begin
            if (act_step_r != `ACT_STEP_DONE) begin
                act_step_r <= act_step_r + 1'b1;
            end
        end else begin
            act_step_r <= '0;
        end
    end

    // Wake timer: loaded on sleep entry, counts down while sleeping
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wake_cnt_r <= '0;
        end else if (mode == MODE_ACTIVE && sleep_req) begin
            wake_cnt_r <= sleep_ticks;
        end else if (mode == MODE_SLEEP && wake_cnt_r != '0) begin
            wake_cnt_r <= wake_cnt_r - 1'b1;
        end
    end

    // Strap caught by a clocked process at the first edge after release
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            boot_taken_r  <= 1'b0;
            boot_from_rom <= 1'b0;
            boot_valid    <= 1'b0;
            lf_xtal_sel_r <= 1'b0;
        end else if (!boot_taken_r) begin
            boot_taken_r  <= 1'b1;
            boot_from_rom <= boot_strap_pin;
            boot_valid    <= 1'b1;
            lf_xtal_sel_r <= lf_xtal_sel;
        end
    end

    // Power domain controls, registered from the next mode
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            power_ctl  <= '0;
            lf_xtal_on <= 1'b0;
            lf_ring_on <= 1'b0;
        end else begin
            power_ctl  <= '0;
            lf_xtal_on <= 1'b0;
            lf_ring_on <= 1'b0;
            unique case (mode_nxt)
                MODE_RESET: begin
                    power_ctl <= '0;
                end
                MODE_WAKE_SEQ: begin
                    power_ctl.regulators_on <= 1'b1;
                    power_ctl.lf_osc_on     <= 1'b1;
                    power_ctl.hf_osc_on     <= act_step_r >= `ACT_STEP_OSC;
                    lf_xtal_on              <= lf_xtal_sel_r;
                    lf_ring_on              <= !lf_xtal_sel_r;
                end
                MODE_SLEEP: begin
                    // Regulators kept for retention; debug port is dark
                    power_ctl.regulators_on <= 1'b1;
                    power_ctl.lf_osc_on     <= 1'b1;
                    lf_xtal_on              <= lf_xtal_sel_r;
                    lf_ring_on              <= !lf_xtal_sel_r;
                end
                MODE_ACTIVE, MODE_RADIO_RX, MODE_RADIO_TX: begin
                    power_ctl.regulators_on <= 1'b1;
                    power_ctl.lf_osc_on     <= 1'b1;
                    power_ctl.hf_osc_on     <= 1'b1;
                    power_ctl.radio_if_on   <= 1'b1;
                    power_ctl.core_run      <= 1'b1;
                    power_ctl.debug_on      <= 1'b1;
                    power_ctl.rx_on <= (mode_nxt == MODE_RADIO_RX);
                    power_ctl.tx_on <= (mode_nxt == MODE_RADIO_TX);
                    lf_xtal_on              <= lf_xtal_sel_r;
                    lf_ring_on              <= !lf_xtal_sel_r;
                end
                default: begin
                    power_ctl <= '0;
                end
            endcase
        end
    end

    // Breakpoint and watchpoint comparators, live only while debug is powered
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_bkpt
            assign bkpt_raw[gi] = addr_match(bkpt_en[gi], pc_addr,
                                             bkpt_addr[gi]);
        end
        for (gi = 0; gi < 2; gi++) begin : g_watch
            assign watch_raw[gi] = addr_match(watch_en[gi] && data_valid,
                                              data_addr,
                                              watch_addr[gi]);
        end
    endgenerate

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            bkpt_hit   <= '0;
            watch_hit  <= '0;
            debug_halt <= 1'b0;
        end else begin
            bkpt_hit   <= power_ctl.debug_on ? bkpt_raw : '0;
            watch_hit  <= power_ctl.debug_on ? watch_raw : '0;
            debug_halt <= power_ctl.debug_on && ((|bkpt_raw) || (|watch_raw));
        end
    end

    serial_rom u_serial_rom (
        .core_clk  (core_clk),
        .rst       (rst),
        .serial_id (serial_id),
        .req       (serial_req),
        .rsp       (serial_rsp)
    );

endmodule

`default_nettype wire

/* tb/power_mode_boot_select_checker.sv */
// Port assertions for the power mode and boot select sequencer
`timescale 1ns/1ps
`default_nettype none
`include "pwr_seq_defs.svh"
module power_mode_boot_select_checker
    import pwr_seq_pkg::*;
(
    input wire logic             core_clk,
    input wire logic             rst,
    input wire power_ctl_t       power_ctl,
    input wire logic             lf_xtal_on,
    input wire logic             lf_ring_on,
    input wire logic             boot_from_rom,
    input wire logic             boot_valid,
    input wire pmode_t           mode,
    input wire logic [47:0]      serial_id,
    input wire serial_req_t      serial_req,
    input wire serial_rsp_t      serial_rsp,
    input wire logic [31:0]      pc_addr,
    input wire logic [3:0][31:0] bkpt_addr,
    input wire logic [3:0]       bkpt_en,
    input wire logic [3:0]       bkpt_hit
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    a_reset_all_off: assert property (disable iff (1'b0)
        rst |-> power_ctl == 8'h00 && mode == MODE_RESET && !boot_valid)
        else $error("outputs live during reset");
    a_wake_seq_len: assert property (
        mode == MODE_WAKE_SEQ && $past(mode) == MODE_RESET
        |-> mode == MODE_WAKE_SEQ [*6] ##1 mode == MODE_ACTIVE)
        else $error("activation sequence length wrong");
    a_sleep_power_off: assert property (mode == MODE_SLEEP
        |-> power_ctl[6:0] == 7'h40 && (lf_xtal_on ^ lf_ring_on))
        else $error("sleep power wrong");
    a_active_power_on: assert property (mode == MODE_ACTIVE
        |-> power_ctl[7:3] == 5'h1f && power_ctl[1:0] == 2'h0)
        else $error("active power wrong");
    a_radio_rx_only: assert property (mode == MODE_RADIO_RX
        |-> power_ctl[5:3] == 3'h7 && power_ctl[1:0] == 2'h2)
        else $error("receive power wrong");
    a_radio_tx_only: assert property (mode == MODE_RADIO_TX
        |-> power_ctl[5:3] == 3'h7 && power_ctl[1:0] == 2'h1)
        else $error("transmit power wrong");
    a_sleep_ends_active: assert property (
        $past(mode) == MODE_SLEEP && mode != MODE_SLEEP |-> mode == MODE_ACTIVE)
        else $error("sleep left to wrong mode");
    a_boot_sel_held: assert property (
        boot_valid && $past(boot_valid) |-> $stable(boot_from_rom))
        else $error("boot source changed");
    a_serial_low_word: assert property (
        serial_req.valid && serial_req.addr == `SERIAL_ADDR_LO |=> serial_rsp
        == {2'h3, $past(serial_id[31:0])})
        else $error("serial low word wrong");
    a_serial_high_word: assert property (
        serial_req.valid && serial_req.addr == `SERIAL_ADDR_HI |=> serial_rsp
        == {2'h3, `SERIAL_PAD, $past(serial_id[47:32])})
        else $error("serial high word wrong");
    a_bkpt_has_cause: assert property (
        bkpt_hit[3] |-> $past(bkpt_en[3] && pc_addr == bkpt_addr[3]))
        else $error("breakpoint hit without match");

    c_sleep_wake: cover property (mode == MODE_SLEEP ##1 mode == MODE_ACTIVE);
    c_radio_tx: cover property (mode == MODE_RADIO_TX);
    c_rom_boot: cover property (boot_valid && boot_from_rom);
endmodule
bind power_mode_boot_select power_mode_boot_select_checker chk (.core_clk,
    .rst, .power_ctl, .lf_xtal_on, .lf_ring_on, .boot_from_rom, .boot_valid,
    .mode, .serial_id, .serial_req, .serial_rsp, .pc_addr, .bkpt_addr,
    .bkpt_en, .bkpt_hit);
`default_nettype wire

/* tb/board_model.sv */
// Board logic model driving system reset and the boot strap
`timescale 1ns/1ps
`default_nettype none
module board_model (
    input  wire logic core_clk,
    input  wire logic do_rst,
    input  wire logic want_rom,
    // Starts low so the first negedge gives the device a real reset edge
    output var logic  rst = 1'b0,
    output var logic  boot_strap_pin = 1'b0
);
    // Moves only after the falling edge so the device samples settled levels
    always @(negedge core_clk) begin
        rst <= do_rst;
        boot_strap_pin <= want_rom;
    end
endmodule
`default_nettype wire

/* tb/power_mode_boot_select_tb.sv */
// Self-checking bench for the power mode and boot select sequencer
`timescale 1ns/1ps
`default_nettype none
`include "pwr_seq_defs.svh"
module power_mode_boot_select_tb;
    import pwr_seq_pkg::*;
    logic                   core_clk = 1'b0;
    logic                   do_rst = 1'b1;
    logic                   want_rom = 1'b0;
    wire logic              rst;
    wire logic              boot_strap_pin;
    logic                   lf_xtal_sel = 1'b1;
    logic                   sleep_req = 1'b0;
    logic                   radio_rx_req = 1'b0;
    logic                   radio_tx_req = 1'b0;
    logic                   radio_done = 1'b0;
    logic [`WAKE_CNT_W-1:0] sleep_ticks = 16'h0;
    logic [47:0]            serial_id = 48'h665544332211;
    serial_req_t            serial_req = 33'h0;
    logic [31:0]            pc_addr = 32'h0;
    logic [3:0][31:0]       bkpt_addr = 128'h0;
    logic [3:0]             bkpt_en = 4'h0;
    logic [31:0]            data_addr = 32'h0;
    logic                   data_valid = 1'b0;
    logic [1:0][31:0]       watch_addr = 64'h0;
    logic [1:0]             watch_en = 2'h0;
    logic [1:0]             watch_hit;
    logic                   debug_halt;
    power_ctl_t             power_ctl;
    logic                   lf_xtal_on, lf_ring_on, boot_from_rom, boot_valid;
    pmode_t                 mode;
    serial_rsp_t            serial_rsp;
    logic [3:0]             bkpt_hit;
    int                     mismatches = 0, n_checks = 0, cycles = 0, n;

    board_model board (.core_clk, .do_rst, .want_rom, .rst, .boot_strap_pin);
    power_mode_boot_select dut (.core_clk, .rst, .boot_strap_pin, .lf_xtal_sel,
        .sleep_req, .sleep_ticks, .radio_rx_req, .radio_tx_req, .radio_done,
        .serial_id, .serial_req, .pc_addr, .data_addr, .data_valid,
        .bkpt_addr, .bkpt_en, .watch_addr, .watch_en, .power_ctl,
        .lf_xtal_on, .lf_ring_on, .boot_from_rom, .boot_valid, .mode,
        .serial_rsp, .debug_halt, .bkpt_hit, .watch_hit);

    initial forever #2 core_clk = ~core_clk;

    task automatic stop_test;
        $display("Checks %0d, mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic ok, input string what);
        n_checks++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("Error at %0t: %s", $time, what);
        end
    endtask

    task automatic t_reset(input logic rom, input logic xtal);
        @(negedge core_clk);
        do_rst <= 1'b1;
        want_rom <= rom;
        lf_xtal_sel = xtal;
        repeat (10) @(negedge core_clk);
        chk(power_ctl === 8'h00 && mode === MODE_RESET, "reset out");
        do_rst <= 1'b0;
        n = 0;
        repeat (12) begin
            @(negedge core_clk);
            if (mode === MODE_WAKE_SEQ) n++;
        end
        // Strap flips after release; the selection must not follow it
        want_rom <= ~rom;
        chk(n == 6 && mode === MODE_ACTIVE, "activation");
        chk(boot_valid === 1'b1 && boot_from_rom === rom, "boot src");
        chk(lf_xtal_on === xtal && lf_ring_on === !xtal, "lf osc");
        chk(power_ctl[7:3] === 5'h1f, "active power");
        repeat (3) @(negedge core_clk);
        chk(boot_from_rom === rom, "boot held");
        want_rom <= 1'b0;
    endtask

    task automatic t_serial;
        @(negedge core_clk);
        serial_req = {1'b1, `SERIAL_ADDR_LO};
        @(negedge core_clk);
        serial_req.addr = `SERIAL_ADDR_HI;
        chk(serial_rsp === {2'h3, serial_id[31:0]}, "serial lo");
        @(negedge core_clk);
        serial_req.addr = 32'h100007fc;
        chk(serial_rsp === {2'h3, `SERIAL_PAD, serial_id[47:32]}, "hi");
        @(negedge core_clk);
        serial_req = 33'h0;
        chk(serial_rsp === {2'h2, 32'h0}, "serial miss");
    endtask

    task automatic t_bkpt;
        @(negedge core_clk);
        bkpt_addr[0] = 32'h00000100;
        bkpt_addr[3] = 32'h00000100;
        bkpt_en = 4'h9;
        pc_addr = 32'h00000100;
        repeat (2) @(negedge core_clk);
        chk(bkpt_hit === 4'h9, "breakpoints");
        watch_addr[1] = 32'h20000010;
        watch_en = 2'h3;
        data_addr = 32'h20000010;
        data_valid = 1'b1;
        repeat (2) @(negedge core_clk);
        chk(watch_hit === 2'h2 && debug_halt === 1'b1, "watch");
        data_valid = 1'b0;
        repeat (2) @(negedge core_clk);
        chk(watch_hit === 2'h0, "watch off");
    endtask

    task automatic t_sleep;
        @(negedge core_clk);
        sleep_req = 1'b1;
        sleep_ticks = 16'h3;
        @(negedge core_clk);
        sleep_req = 1'b0;
        n = 1;
        chk(mode === MODE_SLEEP && power_ctl[6:1] === 6'h20, "sleep");
        repeat (10) begin
            @(negedge core_clk);
            if (mode === MODE_SLEEP) n++;
            if (mode === MODE_SLEEP) chk(bkpt_hit === 4'h0, "dbg");
        end
        chk(n == 4 && mode === MODE_ACTIVE, "wake timer");
        chk(boot_from_rom === 1'b0 && bkpt_hit === 4'h9, "kept");
    endtask

    task automatic t_radio;
        for (int i = 0; i < 2; i++) begin
            @(negedge core_clk);
            radio_rx_req = (i == 0);
            radio_tx_req = 1'b1;
            @(negedge core_clk);
            {radio_rx_req, radio_tx_req, radio_done} = 3'h1;
            chk(mode === (i ? MODE_RADIO_TX : MODE_RADIO_RX), "radio");
            chk(power_ctl[1:0] === (i ? 2'h1 : 2'h2), "rx tx");
            @(negedge core_clk);
            radio_done = 1'b0;
            chk(mode === MODE_ACTIVE, "radio end");
        end
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            stop_test();
        end
    end

    initial begin
        t_reset(1'b0, 1'b1);
        t_serial();
        t_bkpt();
        t_sleep();
        t_radio();
        t_reset(1'b1, 1'b0);
        stop_test();
    end
endmodule
`default_nettype wire
